// ---- verilog/acbr_regs.sv ----
// file: channel b reference code and analog input setup registers
`timescale 1ns/10ps
module acbr_regs (
    input wire logic clk,
    input wire logic reset,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [9:0] avs_address,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [8:0] chb_reference_level_code,
    output logic range_double,
    output logic pseudo_diff_select
);
    // =====================================================================
    // bus front end
    // =====================================================================
    acbr_pkg::acbr_request_type request;
    logic access_strobe;

    assign request.read = avs_read;
    assign request.write = avs_write && !avs_read;
    assign request.address = avs_address;
    assign request.byteenable = avs_byteenable;
    assign request.writedata = avs_writedata;

    acbr_reg_slave front_end (
        .clk(clk),
        .reset(reset),
        .request(request),
        .waitrequest(avs_waitrequest),
        .access_strobe(access_strobe)
    );

    // =====================================================================
    // register state
    // =====================================================================
    logic [7:0] chb_reference_code_low;
    logic chb_reference_code_high;
    acbr_pkg::acbr_input_mode_type analog_input_setup;
    logic [31:0] readdata;
    logic [7:0] next_chb_reference_code_low;
    logic next_chb_reference_code_high;
    acbr_pkg::acbr_input_mode_type next_analog_input_setup;
    logic [31:0] next_readdata;
    logic write_lane0;
    logic read_setup;

    // only byte lane 0 carries register bits; upper lanes are ignored
    assign write_lane0 = access_strobe && request.write && request.byteenable[0];

    // read data is captured in the wait cycle; nothing can move the registers
    // before the taking edge, since a write never shares a request with a read
    assign read_setup = request.read && avs_waitrequest;

    always_comb begin
        next_chb_reference_code_low = chb_reference_code_low;
        next_chb_reference_code_high = chb_reference_code_high;
        next_analog_input_setup = analog_input_setup;
        next_readdata = readdata;
        if (write_lane0) begin
            unique case (request.address)
                acbr_pkg::addr_chb_reference_code_low: begin
                    next_chb_reference_code_low = request.writedata[7:0];
                end
                acbr_pkg::addr_chb_reference_code_high: begin
                    // bits 7-1 are dropped, never stored
                    next_chb_reference_code_high =
                        request.writedata[acbr_pkg::pos_code_top];
                end
                acbr_pkg::addr_analog_input_setup: begin
                    next_analog_input_setup.range_double =
                        request.writedata[acbr_pkg::pos_range_select];
                    next_analog_input_setup.pseudo_diff_select =
                        request.writedata[acbr_pkg::pos_pseudo_diff_select];
                end
                default: begin
                end
            endcase
        end
        if (read_setup) begin
            unique case (request.address)
                acbr_pkg::addr_chb_reference_code_low: begin
                    next_readdata = {24'h000000, chb_reference_code_low};
                end
                acbr_pkg::addr_chb_reference_code_high: begin
                    next_readdata = {31'h00000000, chb_reference_code_high};
                end
                acbr_pkg::addr_analog_input_setup: begin
                    next_readdata = {30'h00000000, analog_input_setup};
                end
                default: begin
                    next_readdata = acbr_pkg::unmapped_read_value;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            chb_reference_code_low <= acbr_pkg::rst_chb_reference_code_low;
            chb_reference_code_high <= acbr_pkg::rst_chb_reference_code_high;
            analog_input_setup <= acbr_pkg::rst_analog_input_setup;
            readdata <= 32'h00000000;
        end else begin
            chb_reference_code_low <= next_chb_reference_code_low;
            chb_reference_code_high <= next_chb_reference_code_high;
            analog_input_setup <= next_analog_input_setup;
            readdata <= next_readdata;
        end
    end

    // =====================================================================
    // outputs to the bus and the analog side
    // =====================================================================
    // read data comes from a flip-flop loaded in the wait cycle; the stall that
    // the front end inserts anyway hides the extra register stage
    always_comb begin
        avs_readdata = readdata;
    end

    // software writes 0x1ff here for a 2.5 volt reference; no check is made
    assign chb_reference_level_code = {chb_reference_code_high, chb_reference_code_low};
    assign range_double = analog_input_setup.range_double;
    assign pseudo_diff_select = analog_input_setup.pseudo_diff_select;

    // =====================================================================
    // checks
    // =====================================================================
    chk_low_write_lands: assert property (@(posedge clk) disable iff (reset)
        (access_strobe && request.write && request.byteenable[0] &&
         request.address == acbr_pkg::addr_chb_reference_code_low)
        |=> chb_reference_level_code[7:0] == $past(request.writedata[7:0]))
        else $error("low reference byte not stored");

    chk_high_read_zero: assert property (@(posedge clk) disable iff (reset)
        (access_strobe && request.read &&
         request.address == acbr_pkg::addr_chb_reference_code_high)
        |-> avs_readdata[31:1] == 31'h00000000)
        else $error("reserved high bits read nonzero");

    chk_code_concat: assert property (@(posedge clk) disable iff (reset)
        (access_strobe && request.write && request.byteenable[0] &&
         request.address == acbr_pkg::addr_chb_reference_code_high)
        |=> chb_reference_level_code ==
            {$past(request.writedata[0]), $past(chb_reference_level_code[7:0])})
        else $error("code top bit mismatch");

    chk_full_code_load: assert property (@(posedge clk) disable iff (reset)
        (access_strobe && request.write && request.byteenable[0] &&
         request.address == acbr_pkg::addr_chb_reference_code_high &&
         request.writedata[0] && chb_reference_code_low == 8'hff)
        |=> chb_reference_level_code == 9'h1ff)
        else $error("full code not reached");

    chk_range_write: assert property (@(posedge clk) disable iff (reset)
        (access_strobe && request.write && request.byteenable[0] &&
         request.address == acbr_pkg::addr_analog_input_setup)
        |=> range_double == $past(request.writedata[1]))
        else $error("range select not stored");

    chk_mode_write: assert property (@(posedge clk) disable iff (reset)
        (access_strobe && request.write && request.byteenable[0] &&
         request.address == acbr_pkg::addr_analog_input_setup)
        |=> pseudo_diff_select == $past(request.writedata[0]))
        else $error("input mode not stored");

    chk_reset_setup: assert property (@(posedge clk)
        $past(reset) |-> (!range_double && !pseudo_diff_select))
        else $error("input setup not zero after reset");

    chk_setup_read_zero: assert property (@(posedge clk) disable iff (reset)
        (access_strobe && request.read &&
         request.address == acbr_pkg::addr_analog_input_setup)
        |-> avs_readdata[31:2] == 30'h00000000)
        else $error("reserved setup bits read nonzero");

    chk_wait_one: assert property (@(posedge clk) disable iff (reset)
        (avs_read && avs_waitrequest) |=> !avs_waitrequest)
        else $error("waitrequest held more than one cycle");

    chk_wait_write: assert property (@(posedge clk) disable iff (reset)
        (avs_write && !avs_read && avs_waitrequest) |=> !avs_waitrequest)
        else $error("write waitrequest held more than one cycle");

    // helper for the checks below: any of the three register addresses
    logic addr_mapped;
    assign addr_mapped = (request.address == acbr_pkg::addr_chb_reference_code_low) ||
        (request.address == acbr_pkg::addr_chb_reference_code_high) ||
        (request.address == acbr_pkg::addr_analog_input_setup);

    chk_high_write_lands: assert property (@(posedge clk) disable iff (reset)
        (access_strobe && request.write && request.byteenable[0] &&
         request.address == acbr_pkg::addr_chb_reference_code_high)
        |=> chb_reference_level_code[8] == $past(request.writedata[0]))
        else $error("high reference bit not stored");

    chk_lane_masked: assert property (@(posedge clk) disable iff (reset)
        (access_strobe && request.write && !request.byteenable[0])
        |=> ($stable(chb_reference_level_code) && $stable(range_double) &&
             $stable(pseudo_diff_select)))
        else $error("write with lane 0 off changed state");

    chk_unmapped_ignored: assert property (@(posedge clk) disable iff (reset)
        (access_strobe && request.write && !addr_mapped)
        |=> ($stable(chb_reference_level_code) && $stable(range_double) &&
             $stable(pseudo_diff_select)))
        else $error("unmapped write changed state");

    chk_unmapped_read_zero: assert property (@(posedge clk) disable iff (reset)
        (access_strobe && request.read && !addr_mapped)
        |-> avs_readdata == 32'h00000000)
        else $error("unmapped read nonzero");

    chk_low_read_back: assert property (@(posedge clk) disable iff (reset)
        (access_strobe && request.read &&
         request.address == acbr_pkg::addr_chb_reference_code_low)
        |-> avs_readdata == {24'h000000, chb_reference_level_code[7:0]})
        else $error("low reference byte read back wrong");

    chk_setup_read_back: assert property (@(posedge clk) disable iff (reset)
        (access_strobe && request.read &&
         request.address == acbr_pkg::addr_analog_input_setup)
        |-> avs_readdata[1:0] == {range_double, pseudo_diff_select})
        else $error("input setup read back wrong");

    chk_reset_code: assert property (@(posedge clk)
        $past(reset) |-> chb_reference_level_code == 9'h000)
        else $error("reference code not zero after reset");
endmodule : acbr_regs

// ---- verilog/acbr_pkg.sv ----
// package: register map, field layout and bus types of the channel b reference slice
package acbr_pkg;

    // =====================================================================
    // register offsets (printed offsets are not multiples of four: index)
    // =====================================================================
    localparam logic [7:0] idx_chb_reference_code_low = 8'h26;
    localparam logic [7:0] idx_chb_reference_code_high = 8'h27;
    localparam logic [7:0] idx_analog_input_setup = 8'h28;
    localparam int addr_width = 10;
    localparam logic [9:0] addr_chb_reference_code_low = 10'h098;
    localparam logic [9:0] addr_chb_reference_code_high = 10'h09c;
    localparam logic [9:0] addr_analog_input_setup = 10'h0a0;

    // =====================================================================
    // field positions and reset values
    // =====================================================================
    localparam int code_width = 9;
    localparam int pos_code_top = 0;
    localparam int pos_range_select = 1;
    localparam int pos_pseudo_diff_select = 0;
    localparam logic [7:0] rst_chb_reference_code_low = 8'h00;
    localparam logic rst_chb_reference_code_high = 1'b0;
    localparam logic [1:0] rst_analog_input_setup = 2'h0;
    localparam logic [31:0] unmapped_read_value = 32'h00000000;

    // =====================================================================
    // bus carrier and input setup record
    // =====================================================================
    typedef struct packed {
        logic read;
        logic write;
        logic [9:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } acbr_request_type;

    typedef struct packed {
        logic range_double;
        logic pseudo_diff_select;
    } acbr_input_mode_type;

endpackage : acbr_pkg

// ---- verilog/acbr_reg_slave.sv ----
// file: avalon-mm slave front end, one wait cycle per access
`timescale 1ns/10ps
module acbr_reg_slave (
    input wire logic clk,
    input wire logic reset,
    input wire acbr_pkg::acbr_request_type request,
    output logic waitrequest,
    output logic access_strobe
);
    // =====================================================================
    // one wait state: the access is taken on the cycle waitrequest is low
    // =====================================================================
    logic busy;
    logic next_busy;

    always_comb begin
        next_busy = 1'b0;
        if ((request.read || request.write) && !busy) begin
            next_busy = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            busy <= 1'b0;
        end else begin
            busy <= next_busy;
        end
    end

    assign waitrequest = (request.read || request.write) && !busy;
    assign access_strobe = (request.read || request.write) && busy;
endmodule : acbr_reg_slave

// ---- sim/acbr_regs_test.sv ----
// testbench: channel b reference code and analog input setup registers
`timescale 1ns/10ps
`define check(got, exp) begin num_checks++; if ((got) !== (exp)) begin fails++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module acbr_regs_test;
    // =====================================================================
    // stimulus and design
    // =====================================================================
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [9:0] avs_address = 10'h000;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [8:0] chb_reference_level_code;
    logic range_double;
    logic pseudo_diff_select;
    logic [31:0] rd;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;

    acbr_regs dut_u (
        .clk(clk),
        .reset(reset),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_address(avs_address),
        .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .chb_reference_level_code(chb_reference_level_code),
        .range_double(range_double),
        .pseudo_diff_select(pseudo_diff_select)
    );

    always #4 clk = ~clk;

    // the whole run needs under a hundred cycles; a hung handshake ends here
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            conclude();
        end
    end

    // =====================================================================
    // bus tasks
    // =====================================================================
    // request held until waitrequest is seen low at a rising edge
    task automatic bus_access(input logic wr, input logic [9:0] addr, input logic [31:0] data,
                              input logic [3:0] be, output logic [31:0] rdata);
        avs_read <= ~wr;
        avs_write <= wr;
        avs_address <= addr;
        avs_byteenable <= be;
        avs_writedata <= data;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // idle edge so the next request is never raised in the release time step
        @(posedge clk);
    endtask : bus_access

    task automatic reg_write(input logic [9:0] addr, input logic [31:0] data,
                             input logic [3:0] be = 4'hf);
        logic [31:0] unused;
        bus_access(1'b1, addr, data, be, unused);
    endtask : reg_write

    task automatic reg_read(input logic [9:0] addr, output logic [31:0] data);
        bus_access(1'b0, addr, 32'h00000000, 4'hf, data);
    endtask : reg_read

    // =====================================================================
    // scenarios
    // =====================================================================
    task automatic test_reset_values();
        reg_read(acbr_pkg::addr_chb_reference_code_low, rd);
        `check(rd, 32'h00000000)
        reg_read(acbr_pkg::addr_chb_reference_code_high, rd);
        `check(rd, 32'h00000000)
        reg_read(acbr_pkg::addr_analog_input_setup, rd);
        `check(rd, 32'h00000000)
        `check({chb_reference_level_code, range_double, pseudo_diff_select}, 11'h000)
        $display("test_reset_values done");
    endtask : test_reset_values

    task automatic test_ref_code();
        reg_write(acbr_pkg::addr_chb_reference_code_low, 32'hffffffa5);
        `check(chb_reference_level_code, 9'h0a5)
        reg_read(acbr_pkg::addr_chb_reference_code_low, rd);
        `check(rd, 32'h000000a5)
        reg_write(acbr_pkg::addr_chb_reference_code_high, 32'hfffffffe);
        reg_read(acbr_pkg::addr_chb_reference_code_high, rd);
        `check(rd, 32'h00000000)
        reg_write(acbr_pkg::addr_chb_reference_code_high, 32'h000000ff);
        reg_read(acbr_pkg::addr_chb_reference_code_high, rd);
        `check(rd, 32'h00000001)
        `check(chb_reference_level_code, 9'h1a5)
        reg_write(acbr_pkg::addr_chb_reference_code_low, 32'h000000ff);
        `check(chb_reference_level_code, 9'h1ff)
        $display("test_ref_code done");
    endtask : test_ref_code

    task automatic test_input_setup();
        for (int i = 0; i < 4; i++) begin
            reg_write(acbr_pkg::addr_analog_input_setup, 32'hfffffffc | 32'(i));
            reg_read(acbr_pkg::addr_analog_input_setup, rd);
            `check(rd, 32'(i))
            `check(range_double, 1'(i >> 1))
            `check(pseudo_diff_select, 1'(i))
        end
        $display("test_input_setup done");
    endtask : test_input_setup

    task automatic test_refused();
        reg_write(10'h0a4, 32'h000000ff);
        reg_read(10'h0a4, rd);
        `check(rd, 32'h00000000)
        // lane 0 disabled: the low byte must keep 0xff
        reg_write(acbr_pkg::addr_chb_reference_code_low, 32'h00000000, 4'he);
        reg_read(acbr_pkg::addr_chb_reference_code_low, rd);
        `check(rd, 32'h000000ff)
        $display("test_refused done");
    endtask : test_refused

    task automatic test_mid_reset();
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        `check({chb_reference_level_code, range_double, pseudo_diff_select}, 11'h000)
        reg_read(acbr_pkg::addr_chb_reference_code_low, rd);
        `check(rd, 32'h00000000)
        reg_read(acbr_pkg::addr_analog_input_setup, rd);
        `check(rd, 32'h00000000)
        $display("test_mid_reset done");
    endtask : test_mid_reset

    // =====================================================================
    // sequence and verdict
    // =====================================================================
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        test_reset_values();
        test_ref_code();
        test_input_setup();
        test_refused();
        test_mid_reset();
        conclude();
    end
endmodule : acbr_regs_test
